// >>> bench/bit_shift_flag_unit_asserts.sv
`timescale 1ns/10ps
module bit_shift_flag_unit_asserts
  import bit_shift_flag_pkg::*;
(
  input wire logic              ref_clk,     // Core clock
  input wire logic              resetn,      // Async reset
  input wire logic              instr_valid, // Offer
  input wire instr_s            instr,       // Instruction
  input wire logic              ready,       // Take
  input wire logic [DATA_W-1:0] flags,       // Flags
  input wire reg_result_s       result,      // Write-back
  input wire logic              io_done      // I/O written
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  wire tk = instr_valid && ready;
  wire io_tk = tk && (instr.op == OP_IO_BIT_RAISE || instr.op == OP_IO_BIT_LOWER);
  a_io_two_cycles: assert property (
    io_tk |=> !ready ##1 (ready && io_done)) else $error("I/O op timing wrong");
  a_io_flags_kept: assert property (
    io_tk |=> $stable(flags) [*2]) else $error("I/O op touched flags");
  a_left_shift: assert property (
    tk && instr.op == OP_LOGICAL_SHIFT_LEFT |=> result.write
    && result.value == {$past(instr.rd_value[6:0]), 1'b0}
    && flags[0] == $past(instr.rd_value[7])) else $error("Left shift wrong");
  a_right_rotate: assert property (
    tk && instr.op == OP_ROTATE_RIGHT_VIA_CARRY |=> result.write
    && result.value == {$past(flags[0]), $past(instr.rd_value[7:1])}
    && flags[0] == $past(instr.rd_value[0])) else $error("Right rotate wrong");
  a_arith_sign_kept: assert property (
    tk && instr.op == OP_ARITHMETIC_SHIFT_RIGHT |=> result.write
    && result.value == {$past(instr.rd_value[7]), $past(instr.rd_value[7:1])}
    && flags[0] == $past(instr.rd_value[0])) else $error("Arith shift wrong");
  a_swap_halves: assert property (
    tk && instr.op == OP_NIBBLE_SWAP |=> result.write && $stable(flags)
    && result.value == {$past(instr.rd_value[3:0]), $past(instr.rd_value[7:4])})
    else $error("Nibble swap wrong");
  a_status_raise: assert property (
    tk && instr.op == OP_STATUS_BIT_RAISE |=>
    flags == ($past(flags) | (8'h01 << $past(instr.bit_sel)))) else $error("Flag raise wrong");
  a_carry_raise: assert property (
    tk && instr.op == OP_CARRY_RAISE |=> flags == ($past(flags) | 8'h01))
    else $error("Carry raise wrong");
endmodule // bit_shift_flag_unit_asserts

// >>> bench/core_decoder_model.sv
`timescale 1ns/10ps
module core_decoder_model
  import bit_shift_flag_pkg::*;
(
  input  wire logic ref_clk,     // Core clock
  input  wire logic ready,       // Unit can take
  output logic      instr_valid, // Offer strobe
  output instr_s    instr        // Held until taken
);
  initial begin
    instr_valid = 1'b0;
    instr = '0;
  end
  // Ready is sampled at the falling edge, where it is settled
  task automatic issue(input instr_s i);
    @(negedge ref_clk);
    instr_valid = 1'b1;
    instr = i;
    while (ready !== 1'b1) @(negedge ref_clk);
    @(negedge ref_clk);
    instr_valid = 1'b0;
    instr = ~i;
  endtask
endmodule // core_decoder_model

// >>> bench/testbench.sv
`timescale 1ns/10ps
module testbench
  import bit_shift_flag_pkg::*;
;
  localparam logic [20:0] IDX = {3'h6, 3'h3, 3'h4, 3'h7, 3'h1, 3'h2, 3'h0};
  logic        ref_clk = 1'b0;
  logic        resetn = 1'b0;
  logic        instr_valid;
  instr_s      instr;
  logic [5:0]  peek_addr = 6'h05;
  logic        ready;
  logic [7:0]  flags;
  reg_result_s result;
  logic        io_done;
  logic [7:0]  peek_data;
  logic [7:0]  ef = FLAGS_RESET;
  logic [7:0]  em;
  int          miscompares = 0;
  int          comparisons = 0;
  int          cycles = 0;
  always #12.5 ref_clk = ~ref_clk;
  core_decoder_model u_core_decoder_model (.ref_clk(ref_clk), .ready(ready),
    .instr_valid(instr_valid), .instr(instr));
  bit_shift_flag_unit u_bit_shift_flag_unit (.ref_clk(ref_clk), .resetn(resetn),
    .instr_valid(instr_valid), .instr(instr), .peek_addr(peek_addr), .ready(ready),
    .flags(flags), .result(result), .io_done(io_done), .peek_data(peek_data));
  task automatic wrap_up;
    if (miscompares == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic op1(input op_e o, input logic [2:0] b, input logic [7:0] rd, rr);
    u_core_decoder_model.issue('{o, b, 6'h05, rd, rr});
    chk(flags, ef);
  endtask
  task automatic io(input op_e o, input logic [2:0] b);
    em[b] = (o == OP_IO_BIT_RAISE);
    op1(o, b, 8'h00, 8'h00);
    chk({7'h0, ready}, 8'h00);
    @(negedge ref_clk);
    chk({7'h0, io_done}, 8'h01);
    @(negedge ref_clk);
    if (^em !== 1'bx) chk(peek_data, em);
  endtask
  task automatic t_io;
    for (int b = 0; b < 8; b++) io(OP_IO_BIT_LOWER, 3'(b));
    io(OP_IO_BIT_RAISE, 3'h3);
    io(OP_IO_BIT_RAISE, 3'h7);
    io(OP_IO_BIT_LOWER, 3'h3);
  endtask
  task automatic t_shift;
    op_e o;
    logic [7:0] rd;
    logic [7:0] v;
    logic c;
    for (int k = 0; k < 18; k++) begin
      o = op_e'(3 + k % 6);
      rd = (k < 6) ? 8'h81 : (k < 12) ? 8'h40 : 8'h00;
      case (o)
        OP_LOGICAL_SHIFT_LEFT:     {c, v} = {rd, 1'b0};
        OP_LOGICAL_SHIFT_RIGHT:    {v, c} = {1'b0, rd};
        OP_ROTATE_LEFT_VIA_CARRY:  {c, v} = {rd, ef[0]};
        OP_ROTATE_RIGHT_VIA_CARRY: {v, c} = {ef[0], rd};
        OP_ARITHMETIC_SHIFT_RIGHT: {v, c} = {rd[7], rd};
        default:                   {v, c} = {rd[3:0], rd[7:4], ef[0]};
      endcase
      // Shifts keep S; V follows N xor C
      if (o != OP_NIBBLE_SWAP) ef[3:0] = {v[7] ^ c, v[7], v == 8'h00, c};
      op1(o, 3'h0, rd, 8'h00);
      chk(result.value, v);
      chk({7'h0, result.write}, 8'h01);
    end
  endtask
  task automatic t_flags;
    logic [2:0] x;
    for (int s = 0; s < 8; s++) begin
      ef[s] = 1'b1;
      op1(OP_STATUS_BIT_RAISE, 3'(s), 8'h00, 8'h00);
    end
    for (int j = 0; j < 7; j++) begin
      x = IDX[3*j+:3];
      ef[x] = 1'b0;
      op1(op_e'(14 + 2 * j), 3'h0, 8'h00, 8'h00);
      ef[x] = 1'b1;
      op1(op_e'(13 + 2 * j), 3'h0, 8'h00, 8'h00);
    end
    ef[5] = 1'b0;
    op1(OP_STATUS_BIT_LOWER, 3'h5, 8'h00, 8'h00);
    ef[5] = 1'b1;
    op1(OP_HALF_CARRY_RAISE, 3'h0, 8'h00, 8'h00);
    for (int s = 0; s < 8; s++) begin
      ef[s] = 1'b0;
      op1(OP_STATUS_BIT_LOWER, 3'(s), 8'h00, 8'h00);
    end
  endtask
  task automatic t_bits;
    ef[6] = 1'b1;
    op1(OP_REGISTER_BIT_TO_TRANSFER_FLAG, 3'h5, 8'h00, 8'h20);
    op1(OP_TRANSFER_FLAG_TO_REGISTER_BIT, 3'h1, 8'h00, 8'h00);
    chk(result.value, 8'h02);
    ef[6] = 1'b0;
    op1(OP_REGISTER_BIT_TO_TRANSFER_FLAG, 3'h4, 8'hFF, 8'h20);
    op1(OP_TRANSFER_FLAG_TO_REGISTER_BIT, 3'h5, 8'hFF, 8'h00);
    chk(result.value, 8'hDF);
  endtask
  // Unknown op must leave state alone; a mid-run reset must restore every output
  task automatic t_reset;
    ef[7] = 1'b1;
    op1(OP_INTERRUPTS_ON, 3'h0, 8'h00, 8'h00);
    op1(OP_NONE, 3'h0, 8'hFF, 8'hFF);
    chk({7'h0, result.write}, 8'h00);
    @(negedge ref_clk);
    resetn = 1'b0;
    @(negedge ref_clk);
    chk(flags, FLAGS_RESET);
    chk(result.value, DATA_RESET);
    chk(peek_data, DATA_RESET);
    chk({5'h0, ready, io_done, result.write}, 8'h04);
    resetn = 1'b1;
    ef = FLAGS_RESET;
    ef[FLAG_C] = 1'b1;
    op1(OP_CARRY_RAISE, 3'h0, 8'h00, 8'h00);
  endtask
  // Whole run is under two hundred cycles
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      miscompares++;
      wrap_up();
    end
  end
  initial begin
    repeat (6) @(negedge ref_clk);
    resetn = 1'b1;
    chk(flags, FLAGS_RESET);
    t_io();
    t_shift();
    t_flags();
    t_bits();
    t_reset();
    wrap_up();
  end
endmodule // testbench
bind bit_shift_flag_unit bit_shift_flag_unit_asserts u_bit_shift_flag_unit_asserts (
  .ref_clk(ref_clk), .resetn(resetn),
  .instr_valid(instr_valid), .instr(instr), .ready(ready), .flags(flags), .result(result),
  .io_done(io_done));

// >>> include/bit_shift_flag_pkg.sv
// Contract
// - io_bit_raise sets chosen I/O register bit, no flag change, two cycles.
// - io_bit_lower clears chosen I/O register bit, no flag change, two cycles.
// - logical_shift_left shifts up, zero into bit 0, updates Z C N V.
// - logical_shift_right shifts down, zero into bit 7, updates Z C N V.
// - rotate_left_via_carry: old carry to bit 0, bit 7 to carry, Z C N V.
// - rotate_right_via_carry: old carry to bit 7, bit 0 to carry, Z C N V.
// - arithmetic_shift_right moves bits 7..1 into 6..0, updates Z C N V, one cycle.
// - nibble exchange swaps register halves in one cycle, flags untouched.
// - status_bit_raise/lower write the selected flag bit only, one cycle.
// - register_bit_to_transfer_flag copies chosen source bit into T, one cycle.
// - transfer_flag_to_register_bit copies T into chosen bit, flags unchanged.
// - carry_raise and carry_lower write only C in one cycle.
// - negative and zero raise/lower write only the named flag, one cycle.
// - interrupts_on/off write only the global interrupt enable, one cycle.
// - sign_test_raise/lower write only S in one cycle.
// - overflow_raise/lower write only V in one cycle.
// - half_carry_raise writes one into H, other flags unchanged.
package bit_shift_flag_pkg;

  localparam int         DATA_W    = 8;
  localparam int         IO_ADDR_W = 6;
  localparam int         IO_DEPTH  = 64;
  localparam logic [2:0] FLAG_C    = 3'h0;
  localparam logic [2:0] FLAG_Z    = 3'h1;
  localparam logic [2:0] FLAG_N    = 3'h2;
  localparam logic [2:0] FLAG_V    = 3'h3;
  localparam logic [2:0] FLAG_S    = 3'h4;
  localparam logic [2:0] FLAG_H    = 3'h5;
  localparam logic [2:0] FLAG_T    = 3'h6;
  localparam logic [2:0] FLAG_I    = 3'h7;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET  = 8'h00;

  typedef enum logic [4:0] {
    OP_NONE,
    OP_IO_BIT_RAISE,
    OP_IO_BIT_LOWER,
    OP_LOGICAL_SHIFT_LEFT,
    OP_LOGICAL_SHIFT_RIGHT,
    OP_ROTATE_LEFT_VIA_CARRY,
    OP_ROTATE_RIGHT_VIA_CARRY,
    OP_ARITHMETIC_SHIFT_RIGHT,
    OP_NIBBLE_SWAP,
    OP_STATUS_BIT_RAISE,
    OP_STATUS_BIT_LOWER,
    OP_REGISTER_BIT_TO_TRANSFER_FLAG,
    OP_TRANSFER_FLAG_TO_REGISTER_BIT,
    OP_CARRY_RAISE,
    OP_CARRY_LOWER,
    OP_NEGATIVE_RAISE,
    OP_NEGATIVE_LOWER,
    OP_ZERO_RAISE,
    OP_ZERO_LOWER,
    OP_INTERRUPTS_ON,
    OP_INTERRUPTS_OFF,
    OP_SIGN_TEST_RAISE,
    OP_SIGN_TEST_LOWER,
    OP_OVERFLOW_RAISE,
    OP_OVERFLOW_LOWER,
    OP_TRANSFER_FLAG_RAISE,
    OP_TRANSFER_FLAG_LOWER,
    OP_HALF_CARRY_RAISE
  } op_e;

  typedef struct packed {
    op_e                  op;
    logic [2:0]           bit_sel;
    logic [IO_ADDR_W-1:0] io_addr;
    logic [DATA_W-1:0]    rd_value;
    logic [DATA_W-1:0]    rr_value;
  } instr_s;

  typedef struct packed {
    logic              write;
    logic [DATA_W-1:0] value;
  } reg_result_s;

endpackage

// >>> rtl/bit_shift_flag_unit.sv
`timescale 1ns/10ps
module bit_shift_flag_unit
  import bit_shift_flag_pkg::*;
(
  input  wire logic                 ref_clk,      // Core clock, 40 MHz
  input  wire logic                 resetn,       // Async reset, active low
  input  wire logic                 instr_valid,  // Instruction offered
  input  wire instr_s               instr,        // Decoded instruction and operands
  input  wire logic [IO_ADDR_W-1:0] peek_addr,    // I/O space observation address
  output logic                      ready,        // Instruction can be taken
  output logic      [DATA_W-1:0]    flags,        // Processor flag register
  output reg_result_s               result,       // Register write-back
  output logic                      io_done,      // I/O bit update written
  output logic      [DATA_W-1:0]    peek_data     // I/O byte at peek_addr
);

  typedef enum logic {ST_IDLE, ST_IO_WRITE} state_e;

  state_e               state_reg,    state_next;
  logic                 ready_reg,    ready_next;
  logic [DATA_W-1:0]    flags_reg,    flags_next;
  reg_result_s          result_reg,   result_next;
  logic                 io_done_reg,  io_done_next;
  logic [IO_ADDR_W-1:0] io_addr_reg,  io_addr_next;
  logic [2:0]           io_bit_reg,   io_bit_next;
  logic                 io_val_reg,   io_val_next;

  logic                 take;
  logic [IO_ADDR_W-1:0] mem_rd_addr;
  logic [DATA_W-1:0]    mem_rd_data;
  logic                 mem_wr_en;
  logic [DATA_W-1:0]    mem_wr_data;

  function automatic logic [7:0] put_bit(input logic [7:0] v, input logic [2:0] idx,
                                         input logic b);
    logic [7:0] r;
    r      = v;
    r[idx] = b;
    return r;
  endfunction

  // Z C N V from a shift result; V is N xor C as for every shift
  function automatic logic [7:0] shift_flags(input logic [7:0] f, input logic [7:0] res,
                                             input logic c);
    logic [7:0] r;
    r         = f;
    r[FLAG_Z] = (res == 8'h00);
    r[FLAG_C] = c;
    r[FLAG_N] = res[7];
    r[FLAG_V] = res[7] ^ c;
    return r;
  endfunction

  assign take    = instr_valid && ready_reg;
  assign ready   = ready_reg;
  assign flags   = flags_reg;
  assign result  = result_reg;
  assign io_done = io_done_reg;

  // Read port is lent to the peek path whenever no I/O update is starting
  assign mem_rd_addr = (take && (instr.op == OP_IO_BIT_RAISE || instr.op == OP_IO_BIT_LOWER))
                       ? instr.io_addr : peek_addr;
  assign mem_wr_en   = (state_reg == ST_IO_WRITE);
  assign mem_wr_data = put_bit(mem_rd_data, io_bit_reg, io_val_reg);

  io_space_mem u_io_space_mem (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .rd_addr (mem_rd_addr),
    .rd_data (mem_rd_data),
    .wr_en   (mem_wr_en),
    .wr_addr (io_addr_reg),
    .wr_data (mem_wr_data)
  );

  // Peek data mirrors the memory read register; holds the old byte at io_addr_reg in ST_IO_WRITE, stale data the cycle after
  assign peek_data = mem_rd_data;

  always_comb begin
    state_next   = state_reg;
    ready_next   = ready_reg;
    flags_next   = flags_reg;
    result_next  = '{write: 1'b0, value: result_reg.value};
    io_done_next = 1'b0;
    io_addr_next = io_addr_reg;
    io_bit_next  = io_bit_reg;
    io_val_next  = io_val_reg;
    case (state_reg)
      ST_IDLE: begin
        if (take) begin
          case (instr.op)
            OP_IO_BIT_RAISE, OP_IO_BIT_LOWER: begin
              // Read this cycle, write the next: two cycles, flags untouched
              io_addr_next = instr.io_addr;
              io_bit_next  = instr.bit_sel;
              io_val_next  = (instr.op == OP_IO_BIT_RAISE);
              ready_next   = 1'b0;
              state_next   = ST_IO_WRITE;
            end
            OP_LOGICAL_SHIFT_LEFT: begin
              result_next = '{write: 1'b1, value: {instr.rd_value[6:0], 1'b0}};
              flags_next  = shift_flags(flags_reg, {instr.rd_value[6:0], 1'b0},
                                        instr.rd_value[7]);
            end
            OP_LOGICAL_SHIFT_RIGHT: begin
              result_next = '{write: 1'b1, value: {1'b0, instr.rd_value[7:1]}};
              flags_next  = shift_flags(flags_reg, {1'b0, instr.rd_value[7:1]},
                                        instr.rd_value[0]);
            end
            OP_ROTATE_LEFT_VIA_CARRY: begin
              result_next = '{write: 1'b1,
                              value: {instr.rd_value[6:0], flags_reg[FLAG_C]}};
              flags_next  = shift_flags(flags_reg, {instr.rd_value[6:0], flags_reg[FLAG_C]},
                                        instr.rd_value[7]);
            end
            OP_ROTATE_RIGHT_VIA_CARRY: begin
              result_next = '{write: 1'b1,
                              value: {flags_reg[FLAG_C], instr.rd_value[7:1]}};
              flags_next  = shift_flags(flags_reg, {flags_reg[FLAG_C], instr.rd_value[7:1]},
                                        instr.rd_value[0]);
            end
            OP_ARITHMETIC_SHIFT_RIGHT: begin
              result_next = '{write: 1'b1,
                              value: {instr.rd_value[7], instr.rd_value[7:1]}};
              flags_next  = shift_flags(flags_reg, {instr.rd_value[7], instr.rd_value[7:1]},
                                        instr.rd_value[0]);
            end
            OP_NIBBLE_SWAP: begin
              result_next = '{write: 1'b1,
                              value: {instr.rd_value[3:0], instr.rd_value[7:4]}};
            end
            OP_STATUS_BIT_RAISE: begin
              flags_next = put_bit(flags_reg, instr.bit_sel, 1'b1);
            end
            OP_STATUS_BIT_LOWER: begin
              flags_next = put_bit(flags_reg, instr.bit_sel, 1'b0);
            end
            OP_REGISTER_BIT_TO_TRANSFER_FLAG: begin
              flags_next = put_bit(flags_reg, FLAG_T, instr.rr_value[instr.bit_sel]);
            end
            OP_TRANSFER_FLAG_TO_REGISTER_BIT: begin
              result_next = '{write: 1'b1,
                              value: put_bit(instr.rd_value, instr.bit_sel,
                                             flags_reg[FLAG_T])};
            end
            OP_CARRY_RAISE:         flags_next = put_bit(flags_reg, FLAG_C, 1'b1);
            OP_CARRY_LOWER:         flags_next = put_bit(flags_reg, FLAG_C, 1'b0);
            OP_NEGATIVE_RAISE:      flags_next = put_bit(flags_reg, FLAG_N, 1'b1);
            OP_NEGATIVE_LOWER:      flags_next = put_bit(flags_reg, FLAG_N, 1'b0);
            OP_ZERO_RAISE:          flags_next = put_bit(flags_reg, FLAG_Z, 1'b1);
            OP_ZERO_LOWER:          flags_next = put_bit(flags_reg, FLAG_Z, 1'b0);
            OP_INTERRUPTS_ON:       flags_next = put_bit(flags_reg, FLAG_I, 1'b1);
            OP_INTERRUPTS_OFF:      flags_next = put_bit(flags_reg, FLAG_I, 1'b0);
            OP_SIGN_TEST_RAISE:     flags_next = put_bit(flags_reg, FLAG_S, 1'b1);
            OP_SIGN_TEST_LOWER:     flags_next = put_bit(flags_reg, FLAG_S, 1'b0);
            OP_OVERFLOW_RAISE:      flags_next = put_bit(flags_reg, FLAG_V, 1'b1);
            OP_OVERFLOW_LOWER:      flags_next = put_bit(flags_reg, FLAG_V, 1'b0);
            OP_TRANSFER_FLAG_RAISE: flags_next = put_bit(flags_reg, FLAG_T, 1'b1);
            OP_TRANSFER_FLAG_LOWER: flags_next = put_bit(flags_reg, FLAG_T, 1'b0);
            OP_HALF_CARRY_RAISE:    flags_next = put_bit(flags_reg, FLAG_H, 1'b1);
            default: begin
              flags_next = flags_reg;
            end
          endcase
        end
      end
      ST_IO_WRITE: begin
        io_done_next = 1'b1;
        ready_next   = 1'b1;
        state_next   = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
        ready_next = 1'b1;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg   <= ST_IDLE;
      ready_reg   <= 1'b1;
      flags_reg   <= FLAGS_RESET;
      result_reg  <= '{write: 1'b0, value: DATA_RESET};
      io_done_reg <= 1'b0;
      io_addr_reg <= '0;
      io_bit_reg  <= 3'h0;
      io_val_reg  <= 1'b0;
    end else begin
      state_reg   <= state_next;
      ready_reg   <= ready_next;
      flags_reg   <= flags_next;
      result_reg  <= result_next;
      io_done_reg <= io_done_next;
      io_addr_reg <= io_addr_next;
      io_bit_reg  <= io_bit_next;
      io_val_reg  <= io_val_next;
    end
  end

endmodule // bit_shift_flag_unit

// >>> rtl/io_space_mem.sv
`timescale 1ns/10ps
module io_space_mem
  import bit_shift_flag_pkg::*;
(
  input  wire logic                 ref_clk,  // Core clock
  input  wire logic                 resetn,   // Async reset, active low
  input  wire logic [IO_ADDR_W-1:0] rd_addr,  // Read address
  output logic      [DATA_W-1:0]    rd_data,  // Registered read data
  input  wire logic                 wr_en,    // Write strobe
  input  wire logic [IO_ADDR_W-1:0] wr_addr,  // Write address
  input  wire logic [DATA_W-1:0]    wr_data   // Write data
);

  logic [DATA_W-1:0] mem [IO_DEPTH];
  logic [DATA_W-1:0] rd_data_reg;

  assign rd_data = rd_data_reg;

  // Array itself has no reset; contents are undefined until written
  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rd_data_reg <= DATA_RESET;
    end else begin
      rd_data_reg <= mem[rd_addr];
    end
  end

endmodule // io_space_mem
